/* design/can_filt_pkg.sv */
// Constants and carrier types for the CAN transmit buffer and filter block.
package can_filt_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] OFS_MODULE_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_TX_FLAG = 8'h06;
  localparam logic [7:0] OFS_TX_CTRL = 8'h07;
  localparam logic [7:0] OFS_ACC_CTRL = 8'h08;
  localparam logic [7:0] OFS_RX_ERR = 8'h0E;
  localparam logic [7:0] OFS_TX_ERR = 8'h0F;
  localparam logic [7:0] OFS_ACC_CODE0 = 8'h10;
  localparam logic [7:0] OFS_ACC_MASK0 = 8'h14;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int SOFT_RESET_BIT = 0;
  localparam int TXE_LSB = 0;
  localparam int ABTAK_LSB = 4;
  localparam int TXEIE_LSB = 0;
  localparam int ABRQ_LSB = 4;
  localparam int HIT_LSB = 0;
  localparam int MODE_LSB = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic SOFT_RESET_RST = 1'b1;
  localparam logic [2:0] TXE_RST = 3'h7;
  localparam logic [2:0] ABTAK_RST = 3'h0;
  localparam logic [2:0] ABRQ_RST = 3'h0;
  localparam logic [2:0] TXEIE_RST = 3'h0;
  localparam logic [1:0] HIT_RST = 2'h0;
  localparam logic [7:0] ACC_BYTE_RST = 8'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_ONE32 = 2'b00,
    MODE_TWO16 = 2'b01,
    MODE_FOUR8 = 2'b10,
    MODE_CLOSED = 2'b11
  } accept_mode_e;

  // Status reported by the protocol engine, one bit per transmit buffer.
  typedef struct packed {
    logic [2:0] done;
    logic [2:0] busy;
    logic [2:0] fail;
  } tx_status_s;

  // A complete message sitting in the background receive buffer.
  typedef struct packed {
    logic valid;
    logic extended;
    logic [3:0][7:0] id;
  } rx_msg_s;

endpackage : can_filt_pkg

/* design/can_tx_buffer_and_id_filter.sv */
// Transmit buffer handshake and identifier acceptance filter of a CAN node.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// Function
// [R1] Abort acknowledge set when message withdrawn.
// [R2] Clearing empty flag clears abort acknowledge.
// [R3] Empty flag set after successful transmission.
// [R4] Software loads buffer, then clears empty.
// [R5] Empty flag set when abort granted.
// [R6] Empty flag set clears abort request.
// [R7] Abort granted only before start or failure.
// [R8] Software sets abort requests, never clears.
// [R9] Software never clears empty and aborts together.
// [R10] Interrupt while empty and enable both set.
// [R11] Software avoids writing scheduled buffers.
// [R12] Soft reset holds flag and control registers.
// [R13] Mode field selects filter organisation.
// [R14] Closed mode accepts no message.
// [R15] Hit field names the accepting filter.
// [R16] Hit field updates on foreground copy.
// [R17] Filter registers writable only in soft reset.
// [R18] Error counters read-only, read when idle.
// [R19] Only accepted messages reach the CPU.
// [R20] Bitwise compare; standard uses two bytes.
// [R21] Mask one ignores bit, zero compares.
// [R22] Standard identifiers mask three low bits.
// [R23] Write one clears empty; acknowledge read-only.
module can_tx_buffer_and_id_filter (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire can_filt_pkg::tx_status_s tx_status,
  input wire can_filt_pkg::rx_msg_s rx_msg,
  input wire logic rx_fg_free,
  input wire logic [7:0] rx_err_count,
  input wire logic [7:0] tx_err_count,
  output logic soft_reset,
  output logic [2:0] tx_empty,
  output logic [2:0] abort_req,
  output logic [2:0] tx_withdrawn,
  output logic tx_irq,
  output logic rx_accept,
  output logic rx_drop
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic soft_q;
  logic [2:0] txe_q, txe_d;
  logic [2:0] abtak_q, abtak_d;
  logic [2:0] abrq_q, abrq_d;
  logic [2:0] txeie_q;
  can_filt_pkg::accept_mode_e mode_q;
  logic [1:0] hit_q, hit_d;
  logic [3:0][7:0] code_q;
  logic [3:0][7:0] mask_q;
  logic [7:0] rdata_q;
  logic [2:0] withdrawn_q;
  logic irq_q;
  logic accept_q;
  logic drop_q;

  logic wr_flag, wr_ctrl, wr_cfg_ok;
  logic [2:0] sw_clr_txe, sw_set_abrq, grant, hw_set_txe;

  assign wr_flag = reg_wr && (reg_addr == can_filt_pkg::OFS_TX_FLAG);
  assign wr_ctrl = reg_wr && (reg_addr == can_filt_pkg::OFS_TX_CTRL);
  assign wr_cfg_ok = reg_wr && soft_q; // [R17]

  // ==========================================================================
  // Module control
  // ==========================================================================
  // Soft reset comes up set, so software must clear it before any transfer.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_q <= can_filt_pkg::SOFT_RESET_RST;
    end else if (reg_wr && (reg_addr == can_filt_pkg::OFS_MODULE_CTRL0)) begin
      soft_q <= reg_wdata[can_filt_pkg::SOFT_RESET_BIT];
    end
  end

  // ==========================================================================
  // Transmit handshake
  // ==========================================================================
  always_comb begin
    sw_clr_txe = wr_flag ? reg_wdata[can_filt_pkg::TXE_LSB +: 3] : 3'h0;
    sw_set_abrq = wr_ctrl ? reg_wdata[can_filt_pkg::ABRQ_LSB +: 3] : 3'h0;
    // Aborts only touch scheduled buffers not completing successfully this cycle.
    grant = abrq_q & ~txe_q & ~tx_status.done
          & (~tx_status.busy | tx_status.fail); // [R7]
    hw_set_txe = (tx_status.done & ~txe_q) | grant; // [R3] [R5]
    // A hardware set wins over a software clear in the same cycle.
    txe_d = (txe_q & ~sw_clr_txe) | hw_set_txe; // [R23]
    abtak_d = (abtak_q & ~(sw_clr_txe & ~hw_set_txe)) | grant; // [R1] [R2]
    abtak_d = abtak_d & ~(tx_status.done & ~txe_q);
    abrq_d = (abrq_q | sw_set_abrq) & ~txe_d; // [R6] [R8]
    if (soft_q) begin
      txe_d = can_filt_pkg::TXE_RST; // [R12]
      abtak_d = can_filt_pkg::ABTAK_RST;
      abrq_d = can_filt_pkg::ABRQ_RST;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txe_q <= can_filt_pkg::TXE_RST;
      abtak_q <= can_filt_pkg::ABTAK_RST;
      abrq_q <= can_filt_pkg::ABRQ_RST;
    end else begin
      txe_q <= txe_d;
      abtak_q <= abtak_d;
      abrq_q <= abrq_d;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txeie_q <= can_filt_pkg::TXEIE_RST;
    end else if (soft_q) begin
      txeie_q <= can_filt_pkg::TXEIE_RST; // [R12]
    end else if (wr_ctrl) begin
      txeie_q <= reg_wdata[can_filt_pkg::TXEIE_LSB +: 3];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      withdrawn_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      withdrawn_q <= soft_q ? 3'h0 : grant;
      irq_q <= |(txe_d & (soft_q ? can_filt_pkg::TXEIE_RST
                                 : (wr_ctrl ? reg_wdata[2:0] : txeie_q))); // [R10]
    end
  end

  // ==========================================================================
  // Acceptance configuration
  // ==========================================================================
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= can_filt_pkg::MODE_ONE32;
    end else if (wr_cfg_ok && (reg_addr == can_filt_pkg::OFS_ACC_CTRL)) begin
      mode_q <= can_filt_pkg::accept_mode_e'(
                  reg_wdata[can_filt_pkg::MODE_LSB +: 2]); // [R13] [R17]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_acc
      always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
          code_q[gi] <= can_filt_pkg::ACC_BYTE_RST;
          mask_q[gi] <= can_filt_pkg::ACC_BYTE_RST;
        end else if (wr_cfg_ok) begin
          if (reg_addr == can_filt_pkg::OFS_ACC_CODE0 + 8'(gi)) begin
            code_q[gi] <= reg_wdata; // [R17]
          end
          if (reg_addr == can_filt_pkg::OFS_ACC_MASK0 + 8'(gi)) begin
            mask_q[gi] <= reg_wdata; // [R17]
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Identifier filter
  // ==========================================================================
  // In the split modes every filter looks at the leading identifier bytes.
  logic [3:0] ok_id0, ok_id1, ok_own;
  logic [3:0] hits;
  logic any_hit;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      // A mask one makes the bit irrelevant; a zero demands equality.
      assign ok_id0[gi] =
        ((code_q[gi] ^ rx_msg.id[0]) & ~mask_q[gi]) == 8'h00; // [R21]
      assign ok_id1[gi] =
        ((code_q[gi] ^ rx_msg.id[1]) & ~mask_q[gi]) == 8'h00; // [R21]
      assign ok_own[gi] =
        ((code_q[gi] ^ rx_msg.id[gi]) & ~mask_q[gi]) == 8'h00; // [R20]
    end
  endgenerate

  always_comb begin
    hits = 4'h0;
    unique case (mode_q)
      can_filt_pkg::MODE_ONE32: begin
        // Standard identifiers only use the first two bytes.
        hits[0] = ok_own[0] && ok_own[1]
               && (!rx_msg.extended || (ok_own[2] && ok_own[3])); // [R20]
      end
      can_filt_pkg::MODE_TWO16: begin
        hits[0] = ok_id0[0] && ok_id1[1];
        hits[1] = ok_id0[2] && ok_id1[3];
      end
      can_filt_pkg::MODE_FOUR8: begin
        hits = ok_id0;
      end
      can_filt_pkg::MODE_CLOSED: begin
        hits = 4'h0; // [R14]
      end
    endcase
    any_hit = |hits;
    // With no hit the encoded value is unused, as the field loads on accept.
    if (hits[0]) begin
      hit_d = 2'h0; // [R15]
    end else if (hits[1]) begin
      hit_d = 2'h1;
    end else if (hits[2]) begin
      hit_d = 2'h2;
    end else begin
      hit_d = 2'h3;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_q <= can_filt_pkg::HIT_RST;
      accept_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      // Rejected messages stay in the background buffer to be overwritten.
      accept_q <= rx_msg.valid && any_hit && rx_fg_free; // [R19]
      drop_q <= rx_msg.valid && !(any_hit && rx_fg_free); // [R19]
      if (rx_msg.valid && any_hit && rx_fg_free) begin
        hit_q <= hit_d; // [R16]
      end
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  // Read data stand for one cycle; otherwise the port shows zero.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        can_filt_pkg::OFS_MODULE_CTRL0: rdata_q <= {7'h00, soft_q};
        can_filt_pkg::OFS_TX_FLAG: rdata_q <= {1'b0, abtak_q, 1'b0, txe_q};
        can_filt_pkg::OFS_TX_CTRL: rdata_q <= {1'b0, abrq_q, 1'b0, txeie_q};
        can_filt_pkg::OFS_ACC_CTRL: rdata_q <= {2'h0, mode_q, 2'h0, hit_q};
        can_filt_pkg::OFS_RX_ERR: rdata_q <= rx_err_count; // [R18]
        can_filt_pkg::OFS_TX_ERR: rdata_q <= tx_err_count; // [R18]
        8'h10, 8'h11, 8'h12, 8'h13: rdata_q <= code_q[reg_addr[1:0]];
        8'h14, 8'h15, 8'h16, 8'h17: rdata_q <= mask_q[reg_addr[1:0]];
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign soft_reset = soft_q;
  assign tx_empty = txe_q;
  assign abort_req = abrq_q;
  assign tx_withdrawn = withdrawn_q;
  assign tx_irq = irq_q;
  assign rx_accept = accept_q;
  assign rx_drop = drop_q;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Hardware reset mutes every property; soft reset is handled inside the seven that name soft_q.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_txe_on_done: assert property ( // [R3]
    (|(tx_status.done & ~txe_q)) |=>
      ((txe_q & $past(tx_status.done)) == $past(tx_status.done)))
    else $error("empty flag not set after successful send");

  a_abort_sets_ack: assert property ( // [R1]
    (!soft_q && (|tx_withdrawn)) |->
      ((abtak_q & txe_q & tx_withdrawn) == tx_withdrawn))
    else $error("granted abort did not set acknowledge and empty");

  a_ack_cleared_txe: assert property ( // [R2]
    (!soft_q && wr_flag && (|(reg_wdata[2:0] & txe_q))) |=>
      ((abtak_q & ~txe_q & $past(reg_wdata[2:0])) == 3'h0))
    else $error("acknowledge survived clearing of empty flag");

  a_abrq_txe_excl: assert property ( // [R6]
    (abrq_q & txe_q) == 3'h0)
    else $error("abort request pending on empty buffer");

  a_abrq_no_swclr: assert property ( // [R8]
    !soft_q |=> ((($past(abrq_q) & ~abrq_q) & ~txe_q) == 3'h0))
    else $error("abort request dropped without empty flag");

  a_grant_gate: assert property ( // [R7]
    (|tx_withdrawn) |->
      ((tx_withdrawn & ~$past(abrq_q)) == 3'h0 &&
       (tx_withdrawn & $past(tx_status.busy & ~tx_status.fail)) == 3'h0))
    else $error("abort granted during running transmission");

  a_irq_level: assert property ( // [R10]
    tx_irq == (|(txe_q & txeie_q)))
    else $error("interrupt disagrees with empty and enable");

  a_soft_holds: assert property ( // [R12]
    soft_q |=> (txe_q == 3'h7 && abtak_q == 3'h0 && abrq_q == 3'h0 &&
                txeie_q == 3'h0))
    else $error("transmit registers not held in soft reset");

  a_cfg_locked: assert property ( // [R17]
    (reg_wr && !soft_q) |=> ($stable(mode_q) && $stable(code_q) &&
                             $stable(mask_q)))
    else $error("filter configuration written outside soft reset");

  a_closed_reject: assert property ( // [R14]
    (mode_q == can_filt_pkg::MODE_CLOSED && rx_msg.valid) |=>
      (!rx_accept ##0 rx_drop))
    else $error("message accepted with filter closed");

  a_hit_on_copy: assert property ( // [R16]
    !$stable(hit_q) |-> rx_accept)
    else $error("hit field changed without a foreground copy");

  a_hit_single32: assert property ( // [R15]
    (rx_accept && $past(mode_q) == can_filt_pkg::MODE_ONE32) |-> hit_q == 2'h0)
    else $error("single filter reported a hit other than zero");

  a_hit_dual16: assert property ( // [R15]
    (rx_accept && $past(mode_q) == can_filt_pkg::MODE_TWO16) |-> !hit_q[1])
    else $error("split filter reported a hit above one");

  a_rx_one_verdict: assert property ( // [R19]
    rx_msg.valid |=> (rx_accept != rx_drop))
    else $error("received message not given exactly one verdict");

  a_rx_err_read: assert property ( // [R18]
    (reg_rd && reg_addr == can_filt_pkg::OFS_RX_ERR) |=>
      (reg_rdata == $past(rx_err_count)))
    else $error("receive error count read back wrongly");

  a_tx_err_read: assert property ( // [R18]
    (reg_rd && reg_addr == can_filt_pkg::OFS_TX_ERR) |=>
      (reg_rdata == $past(tx_err_count)))
    else $error("transmit error count read back wrongly");

  a_grant_empties: assert property ( // [R5]
    (!soft_q && (|grant)) |=> ((txe_q & $past(grant)) == $past(grant)))
    else $error("granted abort did not empty its buffer");

  a_txe_no_sw_set: assert property ( // [R23]
    !soft_q |=> ((txe_q & ~$past(txe_q) & ~$past(hw_set_txe)) == 3'h0))
    else $error("empty flag set without a hardware event");

  a_ack_only_empty: assert property ( // [R1]
    (abtak_q & ~txe_q) == 3'h0)
    else $error("abort acknowledge set on a scheduled buffer");

  c_abort_grant: cover property (|tx_withdrawn);
  c_send_done: cover property (|(tx_status.done & ~txe_q) ##1 tx_irq);
  c_accept_8bit: cover property (
    mode_q == can_filt_pkg::MODE_FOUR8 && rx_msg.valid ##1 rx_accept);
  c_abort_on_fail: cover property (|(abort_req & tx_status.fail));
  c_closed_drop: cover property (
    mode_q == can_filt_pkg::MODE_CLOSED && rx_msg.valid ##1 rx_drop);

endmodule : can_tx_buffer_and_id_filter

`default_nettype wire

/* dv/can_engine_model.sv */
// Behavioural model of the protocol engine and the bus traffic beside the block.
`timescale 1ns/1ns
`default_nettype none

module can_engine_model (
  input wire logic ref_clk,
  output var can_filt_pkg::tx_status_s tx_status,
  output var can_filt_pkg::rx_msg_s rx_msg
);
  initial begin
    tx_status = '0;
    rx_msg = '0;
  end

  // Puts buffer b on the bus; it stays busy until finish is called.
  task automatic start(input int b);
    @(posedge ref_clk);
    tx_status.busy[b] <= 1'b1;
  endtask : start

  // Ends the frame of buffer b: sent when ok is set, lost otherwise.
  task automatic finish(input int b, input bit ok);
    @(posedge ref_clk);
    tx_status.busy[b] <= 1'b0;
    tx_status.done[b] <= ok;
    tx_status.fail[b] <= !ok;
    @(posedge ref_clk);
    tx_status.done <= 3'h0;
    tx_status.fail <= 3'h0;
  endtask : finish

  // A frame sits in the background buffer for one cycle, then is gone.
  task automatic deliver(input bit ext, input logic [31:0] id);
    @(posedge ref_clk);
    rx_msg.valid <= 1'b1;
    rx_msg.extended <= ext;
    rx_msg.id <= id;
    @(posedge ref_clk);
    rx_msg.valid <= 1'b0;
    rx_msg.id <= ~id;
  endtask : deliver
endmodule : can_engine_model

`default_nettype wire

/* dv/test_can_tx_buffer_and_id_filter.sv */
// Self-checking bench for the transmit handshake and acceptance filter.
`timescale 1ns/1ns
`default_nettype none

module test_can_tx_buffer_and_id_filter;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_fg_free = 1'b1;
  logic [7:0] rx_err_count = 8'h5A;
  logic [7:0] tx_err_count = 8'hA5;
  logic [7:0] reg_rdata;
  can_filt_pkg::tx_status_s tx_status;
  can_filt_pkg::rx_msg_s rx_msg;
  logic soft_reset;
  logic [2:0] tx_empty;
  logic [2:0] abort_req;
  logic [2:0] tx_withdrawn;
  logic tx_irq;
  logic rx_accept;
  logic rx_drop;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;

  always #10 ref_clk = ~ref_clk;

  can_tx_buffer_and_id_filter i_can_tx_buffer_and_id_filter (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_status(tx_status), .rx_msg(rx_msg),
    .rx_fg_free(rx_fg_free), .rx_err_count(rx_err_count),
    .tx_err_count(tx_err_count), .soft_reset(soft_reset),
    .tx_empty(tx_empty), .abort_req(abort_req),
    .tx_withdrawn(tx_withdrawn), .tx_irq(tx_irq),
    .rx_accept(rx_accept), .rx_drop(rx_drop)
  );

  can_engine_model i_can_engine_model (
    .ref_clk(ref_clk), .tx_status(tx_status), .rx_msg(rx_msg)
  );

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd

  task automatic cfg(input logic [1:0] m, input logic [7:0] m0,
                     input logic [7:0] m1);
    wr(8'h00, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(8'h10 + 8'(i), 8'h11 * 8'(i + 1));
    end
    wr(8'h14, m0);
    wr(8'h15, m1);
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h00);
    wr(8'h08, {2'b00, m, 4'h0});
    wr(8'h00, 8'h00);
  endtask : cfg

  task automatic rxc(input bit ext, input logic [31:0] id, input bit acc,
                     input logic [7:0] exp_ctrl);
    i_can_engine_model.deliver(ext, id);
    #1;
    chk("accept", 8'(acc), 8'(rx_accept));
    chk("drop", 8'(!acc), 8'(rx_drop));
    rd(8'h08, exp_ctrl, "mode and hit");
  endtask : rxc

  task automatic wait_empty(input int b, input bit wd);
    int n;
    n = 0;
    #1;
    while (tx_empty[b] !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("empty flag", 8'h01, 8'(tx_empty[b]));
    chk("withdrawn", 8'(wd), 8'(tx_withdrawn[b]));
    chk("abort request", 8'h00, 8'(abort_req[b]));
  endtask : wait_empty

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    rd(8'h00, 8'h01, "soft reset");
    chk("soft reset pin", 8'h01, 8'(soft_reset));
    rd(8'h06, 8'h07, "flags");
    rd(8'h07, 8'h00, "control");
    wr(8'h06, 8'h01);
    rd(8'h06, 8'h07, "held flags");
    wr(8'h0E, 8'h00);
    rd(8'h0E, 8'h5A, "rx errors");
    rd(8'h0F, 8'hA5, "tx errors");
    rd(8'h3F, 8'h00, "unmapped");
    $display("test reset done");
  endtask : t_reset

  task automatic t_filter();
    cfg(2'b00, 8'h00, 8'h07);
    wr(8'h08, 8'h30);
    wr(8'h10, 8'hFF);
    rd(8'h08, 8'h00, "locked mode");
    rxc(1'b1, 32'h44332211, 1'b1, 8'h00);
    rxc(1'b1, 32'h45332211, 1'b0, 8'h00);
    rxc(1'b0, 32'hEEEE2711, 1'b1, 8'h00);
    cfg(2'b01, 8'h00, 8'h00);
    rxc(1'b0, 32'h00004433, 1'b1, 8'h11);
    cfg(2'b10, 8'h00, 8'h00);
    rxc(1'b0, 32'h00000033, 1'b1, 8'h22);
    rxc(1'b0, 32'h00000044, 1'b1, 8'h23);
    @(posedge ref_clk);
    rx_fg_free <= 1'b0;
    rxc(1'b0, 32'h00000033, 1'b0, 8'h23);
    @(posedge ref_clk);
    rx_fg_free <= 1'b1;
    cfg(2'b10, 8'hFF, 8'h00);
    rxc(1'b0, 32'h00000099, 1'b1, 8'h20);
    cfg(2'b11, 8'h00, 8'h00);
    rxc(1'b1, 32'h44332211, 1'b0, 8'h30);
    $display("test filter done");
  endtask : t_filter

  task automatic t_tx_send();
    wr(8'h07, 8'h01);
    rd(8'h07, 8'h01, "enables");
    chk("irq", 8'h01, 8'(tx_irq));
    wr(8'h06, 8'h01);
    #1;
    chk("scheduled", 8'h06, 8'(tx_empty));
    rd(8'h06, 8'h06, "flags");
    chk("irq", 8'h00, 8'(tx_irq));
    i_can_engine_model.start(0);
    i_can_engine_model.finish(0, 1'b1);
    wait_empty(0, 1'b0);
    rd(8'h06, 8'h07, "sent flags");
    chk("irq", 8'h01, 8'(tx_irq));
    $display("test send done");
  endtask : t_tx_send

  task automatic t_abort();
    wr(8'h07, 8'h11);
    rd(8'h07, 8'h01, "abort on empty");
    wr(8'h06, 8'h02);
    wr(8'h07, 8'h21);
    wait_empty(1, 1'b1);
    rd(8'h06, 8'h27, "aborted flags");
    wr(8'h06, 8'h02);
    rd(8'h06, 8'h05, "ack cleared");
    wr(8'h06, 8'h04);
    i_can_engine_model.start(2);
    wr(8'h07, 8'h41);
    wr(8'h07, 8'h01);
    rd(8'h07, 8'h41, "pending abort");
    chk("busy buffer", 8'h00, 8'(tx_empty[2]));
    i_can_engine_model.finish(2, 1'b0);
    wait_empty(2, 1'b1);
    rd(8'h06, 8'h45, "failed abort");
    wr(8'h00, 8'h01);
    rd(8'h06, 8'h07, "flags in reset");
    rd(8'h07, 8'h00, "control in reset");
    chk("soft reset pin", 8'h01, 8'(soft_reset));
    $display("test abort done");
  endtask : t_abort

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_filter();
    t_tx_send();
    t_abort();
    conclude();
  end
endmodule : test_can_tx_buffer_and_id_filter

`default_nettype wire
